// ==== src/mso_pkg.sv ====
// Purpose: shared constants for the motion status output block
// Assumes: 40 MHz clock, speed in signed mm/s from the speed estimator
// Notes:   terminal count and widths are plain defaults
package mso_pkg;
	localparam int          SPEED_W        = 16;      // signed speed word width
	localparam int          LEVEL_W        = 13;      // holds 1..5000
	localparam int          TERM_N         = 3;       // number of output terminals
	localparam int          ALLOC_W        = 2;       // terminal select width
	localparam logic [12:0] LEVEL_MIN      = 13'h0001; // least threshold, mm/s
	localparam logic [12:0] LEVEL_MAX      = 13'h1388; // largest threshold, 5000 mm/s
	localparam logic [12:0] LEVEL_RESET    = 13'h0014; // factory value, 20 mm/s
	localparam logic [1:0]  RUN_TERM_RESET = 2'h0;    // default terminal of running output
	localparam logic [1:0]  RDY_TERM_RESET = 2'h1;    // default terminal of ready output

	typedef enum logic [1:0] {
		MSO_NOT_READY = 2'b00,
		MSO_WAIT_POLE = 2'b01,
		MSO_READY     = 2'b10
	} mso_ready_type;
endpackage : mso_pkg

// ==== src/mso_sync.sv ====
// Purpose: two-flop synchroniser for a bus of asynchronous levels
// Assumes: inputs are slow levels; buses must be quasi-static while changing
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module mso_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,   // system clock
	input  wire logic         resetn,  // async reset, active low
	input  wire logic [W-1:0] inLevel, // asynchronous input
	output logic      [W-1:0] outLevel // synchronised copy
);
	logic [W-1:0] stage1_q;

	// plain double flop, reset to zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stage1_q <= '0;
			outLevel <= '0;
		end else begin
			stage1_q <= inLevel;
			outLevel <= stage1_q;
		end
	end
endmodule : mso_sync

// ==== src/mso_status_outputs.sv ====
// Purpose: running and servo-ready active-low status outputs with terminal routing
// Assumes: all inputs come from pins or other domains and are synchronised here
// Notes:   status display bits mirror the logical states, active high
`timescale 1ns/1ps
module mso_status_outputs
	import mso_pkg::*;
(
	input  wire logic                           clock,            // 40 MHz clock
	input  wire logic                           resetn,           // async reset, active low
	input  wire logic signed [mso_pkg::SPEED_W-1:0] motorSpeed,   // measured speed, mm/s
	input  wire logic [mso_pkg::LEVEL_W-1:0]    zeroSpeedLevel,   // threshold, mm/s
	input  wire logic [mso_pkg::ALLOC_W-1:0]    runTermAlloc,     // terminal for running
	input  wire logic [mso_pkg::ALLOC_W-1:0]    rdyTermAlloc,     // terminal for ready
	input  wire logic                           servoOnCmd,       // servo-on request
	input  wire logic                           alarmActive,      // any servo alarm
	input  wire logic                           mainPowerOn,      // main circuit powered
	input  wire logic                           hallFitted,       // hall sensor configured
	input  wire logic                           poleDetectDone,   // polarity detection ok
	output logic [mso_pkg::TERM_N-1:0]          outTerm_n,        // output terminals, low on
	output logic                                dispMoving,       // display: moving
	output logic                                dispReady         // display: servo ready
);
	import mso_pkg::*;

	localparam int SYNC_W = SPEED_W + LEVEL_W + 2 * ALLOC_W + 5;

	logic                        rstMeta_q;
	logic                        rstn_q;
	logic [SYNC_W-1:0]           syncOut;
	logic signed [SPEED_W-1:0]   speedS;
	logic [LEVEL_W-1:0]          levelS;
	logic [ALLOC_W-1:0]          runSelS;
	logic [ALLOC_W-1:0]          rdySelS;
	logic                        servoOnS;
	logic                        alarmS;
	logic                        powerS;
	logic                        hallS;
	logic                        poleS;
	logic [LEVEL_W-1:0]          levelUsed;
	logic                        moving_q;
	mso_ready_type               rdyState_q;
	mso_ready_type               rdyState_d;
	logic                        ready;
	logic                        prepOk;

	// magnitude of the speed word, widened to avoid overflow at the most negative value
	function automatic logic [SPEED_W:0] speedMag(input logic signed [SPEED_W-1:0] s);
		logic [SPEED_W:0] w;
		w = {s[SPEED_W-1], s};
		if (s[SPEED_W-1])
			w = (~w) + 1'b1;
		return w;
	endfunction : speedMag

	// out-of-range threshold is clamped rather than rejected, so a bad write never blinds it
	function automatic logic [LEVEL_W-1:0] clampLevel(input logic [LEVEL_W-1:0] v);
		if (v < LEVEL_MIN)
			return LEVEL_MIN;
		else if (v > LEVEL_MAX)
			return LEVEL_MAX;
		return v;
	endfunction : clampLevel

	// reset release through two flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rstMeta_q <= 1'b0;
			rstn_q    <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstn_q    <= rstMeta_q;
		end
	end

	// every pin input passes two flops before use
	mso_sync #(.W(SYNC_W)) uSync (
		.clock    (clock),
		.resetn   (rstn_q),
		.inLevel  ({motorSpeed, zeroSpeedLevel, runTermAlloc, rdyTermAlloc,
		            servoOnCmd, alarmActive, mainPowerOn, hallFitted, poleDetectDone}),
		.outLevel (syncOut)
	);

	assign {speedS, levelS, runSelS, rdySelS, servoOnS, alarmS, powerS, hallS, poleS} = syncOut;

	// threshold applied each cycle with no latching, so a change acts at once
	assign levelUsed = clampLevel(levelS);

	// movement detection; equality counts as not moving
	always_ff @(posedge clock or negedge rstn_q) begin
		if (!rstn_q)
			moving_q <= 1'b0;
		else
			moving_q <= speedMag(speedS) > {{(SPEED_W + 1 - LEVEL_W){1'b0}}, levelUsed};
	end

	// preparation: no alarm and main power; pole detection unless a hall sensor is fitted is left to the ready state machine
	assign prepOk = !alarmS && powerS;

	always_comb begin
		rdyState_d = rdyState_q;
		case (rdyState_q)
			MSO_NOT_READY: begin
				if (servoOnS && prepOk)
					rdyState_d = MSO_WAIT_POLE;
			end
			MSO_WAIT_POLE: begin
				if (!servoOnS || !prepOk)
					rdyState_d = MSO_NOT_READY;
				else if (hallS || poleS)
					rdyState_d = MSO_READY;
			end
			MSO_READY: begin
				if (!servoOnS || !prepOk || (!hallS && !poleS))
					rdyState_d = MSO_NOT_READY;
			end
			default: rdyState_d = MSO_NOT_READY;
		endcase
	end

	always_ff @(posedge clock or negedge rstn_q) begin
		if (!rstn_q)
			rdyState_q <= MSO_NOT_READY;
		else
			rdyState_q <= rdyState_d;
	end

	assign ready = (rdyState_q == MSO_READY);

	// terminal routing; an unused terminal stays high (off)
	always_ff @(posedge clock or negedge rstn_q) begin
		if (!rstn_q) begin
			outTerm_n <= '1;
		end else begin
			for (int t = 0; t < TERM_N; t++) begin
				outTerm_n[t] <= !((moving_q && runSelS == ALLOC_W'(t))
				               || (ready && rdySelS == ALLOC_W'(t)));
			end
		end
	end

	// display mirrors the same registered states the terminals are built from
	always_ff @(posedge clock or negedge rstn_q) begin
		if (!rstn_q) begin
			dispMoving <= 1'b0;
			dispReady  <= 1'b0;
		end else begin
			dispMoving <= moving_q;
			dispReady  <= ready;
		end
	end

	// running terminal follows movement one cycle later; index taken from the launching cycle
	property p_run_term;
		@(posedge clock) disable iff (!rstn_q)
		(runSelS < ALLOC_W'(TERM_N)) && $stable(runSelS) |=>
			outTerm_n[$past(runSelS)] == !($past(moving_q)
			|| $past(ready && rdySelS == runSelS));
	endproperty
	chk_run_terminal: assert property (p_run_term) else $error("running terminal wrong");

	chk_moving_thresh: assert property (@(posedge clock) disable iff (!rstn_q)
		speedMag(speedS) > {{(SPEED_W + 1 - LEVEL_W){1'b0}}, levelUsed} |=> moving_q)
		else $error("moving not set above threshold");

	chk_level_range: assert property (@(posedge clock) disable iff (!rstn_q)
		levelUsed >= LEVEL_MIN && levelUsed <= LEVEL_MAX) else $error("threshold out of range");

	chk_disp_moving: assert property (@(posedge clock) disable iff (!rstn_q)
		dispMoving == $past(moving_q)) else $error("display moving mismatch");

	sequence s_prep_lost;
		!servoOnS || alarmS || !powerS;
	endsequence
	chk_ready_needs_on: assert property (@(posedge clock) disable iff (!rstn_q)
		s_prep_lost |=> !ready) else $error("ready without servo-on or preparation");

	chk_ready_alarm: assert property (@(posedge clock) disable iff (!rstn_q)
		ready |-> $past(!alarmS && powerS)) else $error("ready during alarm or power off");

	chk_ready_pole: assert property (@(posedge clock) disable iff (!rstn_q)
		ready |-> $past(hallS || poleS)) else $error("ready before polarity detection");

	chk_disp_ready: assert property (@(posedge clock) disable iff (!rstn_q)
		dispReady == $past(ready)) else $error("display ready mismatch");

	chk_ready_terminal: assert property (@(posedge clock) disable iff (!rstn_q)
		$past(ready) && $past(rdySelS) < ALLOC_W'(TERM_N) |-> !outTerm_n[$past(rdySelS)])
		else $error("ready terminal not driven");

	chk_both_dirs: assert property (@(posedge clock) disable iff (!rstn_q)
		speedS == -$past(speedS) && $stable(levelS) && speedS != $past(speedS) |=> $stable(moving_q))
		else $error("direction changed detection");
endmodule : mso_status_outputs

// ==== verif/mso_host_model.sv ====
// Purpose: host controller reading the drive status terminals
// Assumes: host reads a terminal as on when it is pulled low
// Notes:   an unrouted index reads as off
`timescale 1ns/1ps
module mso_host_model
	import mso_pkg::*;
(
	input  wire logic [mso_pkg::TERM_N-1:0]  outTerm_n, // drive terminals, low on
	input  wire logic [mso_pkg::ALLOC_W-1:0] runSel,    // terminal wired as running
	input  wire logic [mso_pkg::ALLOC_W-1:0] rdySel,    // terminal wired as ready
	output logic                             runSeen,   // host sees motion
	output logic                             rdySeen    // host sees servo ready
);
	// index guard keeps an out-of-range select from reading an unknown
	assign runSeen = (runSel < TERM_N) ? ~outTerm_n[runSel] : 1'b0;
	assign rdySeen = (rdySel < TERM_N) ? ~outTerm_n[rdySel] : 1'b0;
endmodule : mso_host_model

// ==== verif/motion_status_outputs_test.sv ====
// Purpose: self-checking bench for the motion status outputs
// Assumes: outputs settle within 8 cycles of an input change
// Notes:   corner cases first, then seeded random traffic
`timescale 1ns/1ps
module motion_status_outputs_test;
	import mso_pkg::*;
	logic                      clock, resetn, runSeen, rdySeen;
	logic signed [SPEED_W-1:0] motorSpeed;
	logic [LEVEL_W-1:0]        zeroSpeedLevel;
	logic [ALLOC_W-1:0]        runTermAlloc, rdyTermAlloc;
	logic [4:0]                ctl; // servo-on, alarm, power, hall, pole done
	logic [TERM_N-1:0]         outTerm_n;
	logic                      dispMoving, dispReady;
	int                        n_fail, comparisons, lv;

	mso_status_outputs DUT (.clock(clock), .resetn(resetn), .motorSpeed(motorSpeed),
		.zeroSpeedLevel(zeroSpeedLevel), .runTermAlloc(runTermAlloc),
		.rdyTermAlloc(rdyTermAlloc), .servoOnCmd(ctl[4]), .alarmActive(ctl[3]),
		.mainPowerOn(ctl[2]), .hallFitted(ctl[1]), .poleDetectDone(ctl[0]),
		.outTerm_n(outTerm_n), .dispMoving(dispMoving), .dispReady(dispReady));
	mso_host_model host (.outTerm_n(outTerm_n), .runSel(runTermAlloc),
		.rdySel(rdyTermAlloc), .runSeen(runSeen), .rdySeen(rdySeen));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// magnitude against the clamped level; equal speed is not motion
	function automatic logic expMoving(input logic signed [15:0] s, input logic [12:0] l);
		int a;
		int c;
		a = s;
		c = (l < LEVEL_MIN) ? LEVEL_MIN : (l > LEVEL_MAX) ? LEVEL_MAX : l;
		if (a < 0) a = -a;
		return a > c;
	endfunction : expMoving

	function automatic logic expReady(input logic [4:0] c);
		return c[4] && !c[3] && c[2] && (c[1] || c[0]);
	endfunction : expReady

	task automatic apply(input int s, input int l, input int ra, input int ya,
		input logic [4:0] c);
		logic m;
		logic r;
		logic [2:0] t;
		motorSpeed = s[15:0];
		zeroSpeedLevel = l[12:0];
		runTermAlloc = ra[1:0];
		rdyTermAlloc = ya[1:0];
		ctl = c;
		repeat (8) @(negedge clock);
		m = expMoving(s[15:0], l[12:0]);
		r = expReady(c);
		for (int i = 0; i < 3; i++) t[i] = !((ra == i && m) || (ya == i && r));
		check(outTerm_n, t);
		check(dispMoving, m);
		check(dispReady, r);
		check(runSeen, ra < 3 && (m || (ra == ya && r)));
		check(rdySeen, ya < 3 && (r || (ra == ya && m)));
	endtask : apply

	// a hang is cut short after several times the expected run length
	initial begin
		#(25 * 20000);
		n_fail++;
		print_verdict();
	end

	initial begin
		resetn = 1'b0;
		{motorSpeed, ctl} = '0;
		zeroSpeedLevel = LEVEL_RESET; // factory settings at power-up
		runTermAlloc = RUN_TERM_RESET;
		rdyTermAlloc = RDY_TERM_RESET;
		n_fail = 0;
		comparisons = 0;
		void'($urandom(32'hB760));
		repeat (20) @(negedge clock);
		check(outTerm_n, 3'h7);
		check(dispMoving, 1'b0);
		check(dispReady, 1'b0);
		resetn = 1'b1;
		// factory threshold and default terminals
		apply(21, LEVEL_RESET, RUN_TERM_RESET, RDY_TERM_RESET, 5'h16);
		apply(-20, LEVEL_RESET, RUN_TERM_RESET, RDY_TERM_RESET, 5'h15);
		// threshold edges in both directions, plus clamped; pairs are exact negations
		for (int k = 0; k < 6; k++) begin
			lv = 1 + $urandom % 5000;
			apply(lv, lv, k % 3, 1, 5'h14);
			apply(-lv, lv, k % 3, 1, 5'h14);
			apply(lv + 1, lv, k % 3, 1, 5'h14);
			apply(-lv - 1, lv, k % 3, 1, 5'h14);
		end
		apply(2, 0, 0, 1, 5'h00);
		apply(1, 0, 0, 1, 5'h00);
		apply(5001, 8191, 2, 0, 5'h00);
		apply(5000, 8191, 2, 0, 5'h00);
		// every ready condition combination, with routing moved around
		for (int i = 0; i < 32; i++) apply(100, 20, i % 3, (i + 1) % 4, i[4:0]);
		// reset in mid-run drops both outputs at once, whatever was on
		resetn = 1'b0;
		@(negedge clock);
		check(outTerm_n, 3'h7);
		check(dispMoving, 1'b0);
		check(dispReady, 1'b0);
		resetn = 1'b1;
		for (int i = 0; i < 150; i++)
			apply(int'($signed(16'($urandom))), $urandom % 5200, $urandom % 3,
				$urandom % 4, 5'($urandom));
		print_verdict();
	end
endmodule : motion_status_outputs_test
